// ### dv/charger_host_model.sv
module charger_host_model (
  // Clock and register bus
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_rd = 1'h0,
  output logic reg_wr = 1'h0,
  output logic [7:0] reg_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  // Callers read the fault register before a write-one clear
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= !w;
    reg_wr <= w;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    reg_wr <= 1'h0;
    // Released data carries no meaning, so it is scrambled
    reg_wdata <= ~d;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
endmodule

// ### dv/charger_status_fault_regs_asserts.sv
module charger_status_asserts (
  // Watched ports
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic input_overvoltage_flag,
  input wire logic thermal_shutdown_detect,
  input wire logic input_supply_good,
  input wire logic device_shutdown
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence
  // Long enough to cover the sync stages and the filter
  sequence supply_steady;
    input_supply_good [*8];
  endsequence
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'h08 || reg_addr > 8'h0a) |=> reg_rdata == 8'h00) else $error("unmapped");
  flags_gap_a: assert property (rd_at(8'h08) |=> !reg_rdata[6]) else $error("bit6");
  zone_gap_a: assert property (rd_at(8'h09) |=> !reg_rdata[3]) else $error("bit3");
  fault_top_a: assert property (
    rd_at(8'h0a) |=> reg_rdata[7:4] == 4'h0) else $error("fault top");
  overvoltage_read_a: assert property (
    input_overvoltage_flag [*7] ##0 rd_at(8'h08) |=> reg_rdata[7]) else $error("ov");
  tsd_shutdown_a: assert property (
    thermal_shutdown_detect [*8] |-> device_shutdown) else $error("no shutdown");
  tsd_flag_a: assert property (
    thermal_shutdown_detect [*8] ##0 rd_at(8'h0a) |=> reg_rdata[0]) else $error("tsd flag");
  shutdown_held_a: assert property (
    supply_steady ##0 device_shutdown |=> device_shutdown) else $error("released");
endmodule
bind charger_status_fault_regs charger_status_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .input_overvoltage_flag(input_overvoltage_flag),
  .thermal_shutdown_detect(thermal_shutdown_detect),
  .input_supply_good(input_supply_good), .device_shutdown(device_shutdown));

// ### dv/charger_status_fault_regs_bench.sv
module charger_status_fault_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'h0, rst = 1'h1, ov = 1'h0, il = 1'h0, dt = 1'h0, ce = 1'h0, cr = 1'h0;
  logic pk = 1'h0, pn = 1'h0, bs = 1'h0, tw = 1'h0, ts = 1'h0, sg = 1'h1, psd = 1'h1;
  logic [2:0] cs = 3'h0, tz = 3'h0, bc = 3'h0;
  logic rd, wr, down;
  logic [7:0] ad, wd, rdata, q;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  charger_status_fault_regs u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(ad), .reg_rd(rd),
    .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdata), .input_overvoltage_flag(ov),
    .input_current_limited_flag(il), .die_thermal_limit_flag(dt), .charge_end_event(ce),
    .charge_restart(cr), .charger_state_code(cs), .thermistor_zone_code(tz),
    .battery_class_code(bc), .peak_limit_event(pk), .peak_normal_cycle(pn),
    .battery_short_detect(bs), .thermal_warn_detect(tw), .thermal_shutdown_detect(ts),
    .input_supply_good(sg), .peak_shutdown_disable(psd), .device_shutdown(down));
  charger_host_model u_host (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(ad),
    .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] a, e);
    u_host.acc(1'h0, a, 8'h00, q);
    comparisons++;
    if (q !== e) begin
      n_fail++;
      $display("[FAIL] %0t reg %h got %h exp %h", $time, a, q, e);
    end
  endtask
  task automatic chk_down(input logic e);
    comparisons++;
    if (down !== e) begin
      n_fail++;
      $display("[FAIL] %0t shutdown %b", $time, down);
    end
  endtask
  task automatic peaks(input int n);
    repeat (n) begin
      pk <= 1'h1;
      tick(6);
      pk <= 1'h0;
      tick(6);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    tick(6);
    rst <= 1'h0;
    chk(8'h0a, 8'h00);
    chk(8'h05, 8'h00);
    {ov, il, dt} <= 3'h7;
    for (int i = 0; i < 8; i++) begin
      {cs, tz, bc} <= {3{i[2:0]}};
      tick(8);
      chk(8'h08, {4'hb, 1'h0, i[2:0]});
      chk(8'h09, {i[2:0], 2'h0, i[2:0]});
    end
    ce <= 1'h1;
    tick(8);
    ce <= 1'h0;
    tick(8);
    chk(8'h08, 8'hbf);
    u_host.acc(1'h1, 8'h08, 8'h00, q);
    chk(8'h08, 8'hbf);
    // Levels low and a new charge start drop every status bit but the code
    {ov, il, dt, cr} <= 4'h1;
    tick(8);
    cr <= 1'h0;
    tick(8);
    chk(8'h08, 8'h07);
    $display("status test done");
    peaks(3);
    chk(8'h09, 8'he7);
    peaks(1);
    chk(8'h09, 8'hf7);
    chk(8'h0a, 8'h04);
    chk_down(1'h0);
    {bs, tw} <= 2'h3;
    tick(8);
    {bs, tw} <= 2'h0;
    tick(8);
    // Write without a fresh read must not clear anything
    u_host.acc(1'h1, 8'h0a, 8'h00, q);
    u_host.acc(1'h1, 8'h0a, 8'h0f, q);
    chk(8'h0a, 8'h0e);
    u_host.acc(1'h1, 8'h0a, 8'h02, q);
    chk(8'h0a, 8'h0c);
    $display("fault test done");
    pn <= 1'h1;
    tick(8);
    {pn, psd} <= 2'h0;
    chk(8'h09, 8'he7);
    peaks(4);
    chk_down(1'h1);
    ts <= 1'h1;
    tick(8);
    chk(8'h0a, 8'h0d);
    ts <= 1'h0;
    chk_down(1'h1);
    sg <= 1'h0;
    tick(8);
    sg <= 1'h1;
    tick(8);
    chk(8'h0a, 8'h00);
    chk_down(1'h0);
    // Thermal shutdown alone, with no other cause holding the device down
    ts <= 1'h1;
    tick(8);
    chk_down(1'h1);
    ts <= 1'h0;
    tick(8);
    chk(8'h0a, 8'h01);
    // Reset in mid-run wipes the latched fault and the shutdown
    rst <= 1'h1;
    tick(6);
    rst <= 1'h0;
    chk(8'h0a, 8'h00);
    chk_down(1'h0);
    $display("shutdown test done");
    finish_test();
  end
endmodule

// ### rtl/charger_status_defines.vh
`ifndef CHARGER_STATUS_DEFINES_VH
`define CHARGER_STATUS_DEFINES_VH
// Register offsets
`define OFS_STATE_FLAGS 8'h08
`define OFS_THERM_BATT 8'h09
`define OFS_FAULT_FLAGS 8'h0a
// Field positions
`define BIT_OVERVOLTAGE 7
`define BIT_CURRENT_LIMITED 5
`define BIT_DIE_THERMAL 4
`define BIT_CHARGE_COMPLETE 3
`define BIT_REPEATED_PEAK 4
`define BIT_BATTERY_SHORT 3
`define BIT_INDUCTOR_PEAK 2
`define BIT_THERMAL_WARN 1
`define BIT_THERMAL_SHUTDOWN 0
// Reset values
`define FAULT_RESET 4'h0
// Peak events in a row that count as repeated
`define PEAK_REPEAT_COUNT 3'h4
`endif

// ### rtl/charger_status_fault_regs.v
// Functional notes
// RULE1: Status bit 7 follows input overvoltage level.
// RULE2: Status bit 5 shows input current limited by blocking transistor.
// RULE3: Status bit 4 shows charge current reduced by die temperature.
// RULE4: Bit 3 sets at end of charge and stays latched.
// RULE5: 3-bit charger state code 000..111 as listed.
// RULE6: Thermistor zone reported in bits 7:5.
// RULE7: Peak status bit 4 set after four or more consecutive peaks.
// RULE8: Battery class reported in bits 2:0.
// RULE9: Fault bit 3 latches battery short until cleared.
// RULE10: Fault bit 2 latches inductor peak fault.
// RULE11: Fault bit 1 latches early thermal warning.
// RULE12: Fault bit 0 latches thermal shutdown and shuts device down.
// RULE13: Fault cleared by read then write one, or input power cycle.
// RULE14: All fault flags zero after reset until a fault.
// RULE15: Peak shutdown disable high only flags; low shuts down.
// RULE16: Unused bits read zero; writes to them and read-only fields ignored.
`include "charger_status_defines.vh"
module charger_status_fault_regs (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register access from the serial host interface
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Analog condition inputs (asynchronous)
  input wire input_overvoltage_flag,
  input wire input_current_limited_flag,
  input wire die_thermal_limit_flag,
  input wire charge_end_event,
  input wire charge_restart,
  input wire [2:0] charger_state_code,
  input wire [2:0] thermistor_zone_code,
  input wire [2:0] battery_class_code,
  input wire peak_limit_event,
  input wire peak_normal_cycle,
  input wire battery_short_detect,
  input wire thermal_warn_detect,
  input wire thermal_shutdown_detect,
  input wire input_supply_good,
  // Control and results
  input wire peak_shutdown_disable,
  output reg device_shutdown
);

  // Sync: 3 stages per async bit; change accepted when stages 2 and 3 agree
  // Codes are filtered bit by bit, so a code that changes while a read lands
  // can show a mix of old and new bits for one cycle
  localparam NSYNC = 20;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] s1_reg;
  reg [NSYNC-1:0] s2_reg;
  reg [NSYNC-1:0] s3_reg;
  reg [NSYNC-1:0] filt_reg;
  assign raw_in = {input_overvoltage_flag, input_current_limited_flag, die_thermal_limit_flag,
    charge_end_event, charge_restart, charger_state_code, thermistor_zone_code,
    battery_class_code, peak_limit_event, peak_normal_cycle, battery_short_detect,
    thermal_warn_detect, thermal_shutdown_detect, input_supply_good};

  always @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= {NSYNC{1'b0}};
      s2_reg <= {NSYNC{1'b0}};
      s3_reg <= {NSYNC{1'b0}};
      filt_reg <= {NSYNC{1'b0}};
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end

  wire ov_f = filt_reg[19];
  wire ilim_f = filt_reg[18];
  wire dtl_f = filt_reg[17];
  wire end_f = filt_reg[16];
  wire restart_f = filt_reg[15];
  wire [2:0] state_f = filt_reg[14:12];
  wire [2:0] zone_f = filt_reg[11:9];
  wire [2:0] batt_f = filt_reg[8:6];
  wire peak_f = filt_reg[5];
  wire normal_f = filt_reg[4];
  wire short_f = filt_reg[3];
  wire warn_f = filt_reg[2];
  wire tsd_f = filt_reg[1];
  wire supply_f = filt_reg[0];

  // One-cycle pulse where a filtered level goes from low to high
  function went_high;
    input now_level;
    input last_level;
    begin
      went_high = now_level & ~last_level;
    end
  endfunction

  // Edge history for event detection on filtered levels
  reg peak_d_reg;
  reg normal_d_reg;
  reg supply_d_reg;
  reg fault_read_reg;
  reg charge_complete_reg;
  reg repeated_peak_reg;
  reg [2:0] peak_run_reg;
  reg [3:0] fault_reg;
  reg [3:0] fault_next;
  wire peak_rise = went_high(peak_f, peak_d_reg);
  wire normal_rise = went_high(normal_f, normal_d_reg);
  // A supply drop clears the faults in that cycle; the fault set still wins if present
  wire supply_cycle = went_high(~supply_f, ~supply_d_reg);
  // Address decode shared by the read-arm and the write-clear paths
  wire fault_addr = (reg_addr == `OFS_FAULT_FLAGS);
  wire [3:0] wr_clear = (reg_wr && fault_addr && fault_read_reg) ? reg_wdata[3:0] : 4'h0;
  wire peak_repeat = peak_rise && (peak_run_reg >= `PEAK_REPEAT_COUNT - 3'h1);
  wire [3:0] fault_set;
  wire shutdown_cause;
  wire [7:0] state_word;
  wire [7:0] therm_word;
  wire [7:0] fault_word;

  assign fault_set[`BIT_BATTERY_SHORT] = short_f; // RULE9
  assign fault_set[`BIT_INDUCTOR_PEAK] = peak_repeat; // RULE10
  assign fault_set[`BIT_THERMAL_WARN] = warn_f; // RULE11
  assign fault_set[`BIT_THERMAL_SHUTDOWN] = tsd_f; // RULE12
  // Repeated peaks only stop the device when the disable control is low
  assign shutdown_cause = tsd_f | (peak_repeat & ~peak_shutdown_disable); // RULE12 RULE15

  // Read-back words built from the filtered levels and the latches
  assign state_word[`BIT_OVERVOLTAGE] = ov_f; // RULE1
  assign state_word[6] = 1'b0; // RULE16
  assign state_word[`BIT_CURRENT_LIMITED] = ilim_f; // RULE2
  assign state_word[`BIT_DIE_THERMAL] = dtl_f; // RULE3
  assign state_word[`BIT_CHARGE_COMPLETE] = charge_complete_reg; // RULE4
  assign state_word[2:0] = state_f; // RULE5
  assign therm_word[7:5] = zone_f; // RULE6
  assign therm_word[`BIT_REPEATED_PEAK] = repeated_peak_reg; // RULE7
  assign therm_word[3] = 1'b0; // RULE16
  assign therm_word[2:0] = batt_f; // RULE8
  assign fault_word = {4'h0, fault_reg}; // RULE16

  always @* begin
    fault_next = fault_reg & ~wr_clear; // RULE13
    if (supply_cycle) begin
      fault_next = 4'h0; // RULE13
    end
    fault_next = fault_next | fault_set;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      peak_d_reg <= 1'b0;
      normal_d_reg <= 1'b0;
      supply_d_reg <= 1'b0;
      fault_read_reg <= 1'b0;
      repeated_peak_reg <= 1'b0;
      peak_run_reg <= 3'h0;
      fault_reg <= `FAULT_RESET; // RULE14
    end else begin
      peak_d_reg <= peak_f;
      normal_d_reg <= normal_f;
      supply_d_reg <= supply_f;
      fault_reg <= fault_next;
      // Clear needs a prior read of the fault register; a write uses it up
      if (reg_rd && fault_addr) begin
        fault_read_reg <= 1'b1; // RULE13
      end else if (reg_wr && fault_addr) begin
        fault_read_reg <= 1'b0;
      end
      // Run counter saturates so a long streak cannot wrap back to zero
      if (normal_rise) begin
        peak_run_reg <= 3'h0; // RULE7
      end else if (peak_rise && peak_run_reg != 3'h7) begin
        peak_run_reg <= peak_run_reg + 3'h1;
      end
      if (normal_rise) begin
        repeated_peak_reg <= 1'b0;
      end else if (peak_repeat) begin
        repeated_peak_reg <= 1'b1; // RULE7
      end
    end
  end

  // Latch survives recharge threshold; only a new charge start drops it
  always @(posedge sys_clk) begin
    if (rst) begin
      charge_complete_reg <= 1'b0;
    end else if (end_f) begin
      charge_complete_reg <= 1'b1; // RULE4
    end else if (restart_f) begin
      charge_complete_reg <= 1'b0;
    end
  end

  // Shutdown holds until every cause is gone and the supply has dropped
  always @(posedge sys_clk) begin
    if (rst) begin
      device_shutdown <= 1'b0;
    end else if (shutdown_cause) begin
      device_shutdown <= 1'b1; // RULE12 RULE15
    end else if (supply_cycle) begin
      device_shutdown <= 1'b0;
    end
  end

  // Read mux, registered
  // Read data stands until the next read so a slow host can still fetch it
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_STATE_FLAGS: reg_rdata <= state_word; // RULE1 RULE2 RULE3 RULE4 RULE5
        `OFS_THERM_BATT: reg_rdata <= therm_word; // RULE6 RULE7 RULE8
        `OFS_FAULT_FLAGS: reg_rdata <= fault_word; // RULE9 RULE10 RULE11 RULE12
        default: reg_rdata <= 8'h00; // RULE16
      endcase
    end
  end

endmodule
